// *** design/bcca_core.sv ***
// Bus cycle control, termination, arbitration and reset pin handling
// What this block does
// - Direction high for read, low for write
// - Size field encodes transfer size, monitored
// - Drive transfer type, ignore for alternates
// - Normal accesses: modifier from supervisor and code
// - Other types: fixed or debug-like modifier values
// - Start strobe low exactly one clock
// - Watch alternate master start strobes
// - Sync acknowledge ends cycles, not own DRAM
// - Drive acknowledge for alternate cycles we serve
// - Synchronise async acknowledge, falling-edge data
// - Error acknowledge aborts, beats other acknowledges
// - Late error honoured; no effect on DRAM
// - Request until access starts, then negate
// - Take bus on grant, release unless locked
// - Bus-driven on grant with pending or lock
// - Grant lost unlocked: finish, release, tristate
// - Grant lost idle locked: keep bus-driven
// - Reset pin tristates bus, negates request, driven
// - Reset with high-impedance select: master reset
// - Reset without it: refresh keeps running
`timescale 1ns/100ps
`default_nettype none
module bcca_core #(
  parameter int AW = 32,
  parameter int DW = 32,
  parameter int WSW = 4
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic req_valid,
  input wire logic req_read,
  input wire logic [bcca_pkg::SIZE_W-1:0] req_size,
  input wire logic [bcca_pkg::TT_W-1:0] req_type,
  input wire logic [bcca_pkg::MOD_W-1:0] req_mod,
  input wire logic req_dram,
  input wire logic [AW-1:0] req_addr,
  input wire logic [DW-1:0] req_wdata,
  input wire logic dram_done,
  input wire logic bus_lock,
  output logic req_accept,
  output logic xfer_done,
  output logic xfer_error,
  output logic [DW-1:0] xfer_rdata,
  output logic [AW-1:0] addr_o,
  output logic addr_oe,
  input wire logic [DW-1:0] data_i,
  output logic [DW-1:0] data_o,
  output logic data_oe,
  input wire logic rw_i,
  output logic rw_o,
  output logic rw_oe,
  input wire logic [bcca_pkg::SIZE_W-1:0] size_i,
  output logic [bcca_pkg::SIZE_W-1:0] size_o,
  output logic size_oe,
  output logic [bcca_pkg::TT_W-1:0] transfer_type_field_o,
  output logic transfer_type_field_oe,
  output logic access_modifier_o,
  output logic access_modifier_oe,
  input wire logic cycle_start_strobe_n_i,
  output logic cycle_start_strobe_n_o,
  output logic cycle_start_strobe_oe,
  input wire logic sync_slave_ack_n_i,
  output logic sync_slave_ack_n_o,
  output logic sync_slave_ack_oe,
  input wire logic async_slave_ack_n,
  input wire logic error_slave_ack_n,
  output logic bus_request_out_n,
  input wire logic bus_grant_in_n,
  output logic bus_owned_out_n,
  input wire logic alt_cs_hit,
  input wire logic alt_dram_hit,
  input wire logic alt_master_auto_ack,
  input wire logic [WSW-1:0] alt_wait_states,
  input wire logic alt_dram_done,
  output logic alt_cycle_start,
  output logic alt_read,
  output logic [bcca_pkg::SIZE_W-1:0] alt_size,
  input wire logic reset_input_pin_n,
  input wire logic high_impedance_select_n,
  output logic reset_exception,
  output logic in_reset,
  output logic master_reset_mode,
  output logic refresh_reset
);
  import bcca_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    bcca_state_e st;
    logic br_n;
    logic own_n;
    logic ts_n;
    logic drv;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic data_oe;
    logic rw;
    logic [SIZE_W-1:0] size;
    logic [TT_W-1:0] tt;
    logic access_modifier;
    logic atm_after;
    logic dram;
    logic accept;
    logic done;
    logic err;
    logic [DW-1:0] rdata;
    logic alt_start;
    logic alt_read;
    logic [SIZE_W-1:0] alt_size;
    logic alt_dram;
    logic [WSW-1:0] alt_cnt;
    logic ta_n;
    logic ta_oe;
    logic rst_exc;
    logic in_rst;
    logic master_rst;
    logic refresh_rst;
  } bcca_core_s;

  localparam bcca_core_s CORE_RST = '{st: ST_IDLE, br_n: PIN_NEGATED_N, own_n: PIN_NEGATED_N,
    ts_n: PIN_NEGATED_N, ta_n: PIN_NEGATED_N, default: '0};

  bcca_core_s state_r;
  bcca_core_s state_nxt;
  logic granted;
  logic ata_seen;
  logic [DW-1:0] ata_data;
  logic ata_arm;

  // grant and acknowledges used as sampled at the rising edge
  assign granted = ~bus_grant_in_n;
  // Armed only while our own non-DRAM cycle waits, so stale captures clear
  assign ata_arm = (state_r.st == ST_WAIT) && !state_r.dram;

  // async acknowledge through a two-stage synchroniser
  bcca_ack_sync #(
    .DW(DW)
  ) u_ack_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .async_slave_ack_n(async_slave_ack_n),
    .arm(ata_arm),
    .data_i(data_i),
    .ack_seen(ata_seen),
    .data_held(ata_data)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    state_nxt = state_r;
    state_nxt.accept = 1'b0;
    state_nxt.done = 1'b0;
    state_nxt.err = 1'b0;
    state_nxt.alt_start = 1'b0;
    state_nxt.rst_exc = 1'b0;
    if (!reset_input_pin_n) begin
      state_nxt.st = ST_IDLE;
      state_nxt.br_n = PIN_NEGATED_N;
      state_nxt.own_n = PIN_NEGATED_N;
      state_nxt.ts_n = PIN_NEGATED_N;
      state_nxt.drv = 1'b0;
      state_nxt.data_oe = 1'b0;
      state_nxt.ta_n = PIN_NEGATED_N;
      state_nxt.ta_oe = 1'b0;
      state_nxt.rst_exc = ~state_r.in_rst;
      state_nxt.in_rst = 1'b1;
      state_nxt.master_rst = ~high_impedance_select_n;
      state_nxt.refresh_rst = ~high_impedance_select_n;
    end else begin
      state_nxt.in_rst = 1'b0;
      state_nxt.master_rst = 1'b0;
      state_nxt.refresh_rst = 1'b0;
      case (state_r.st)
        ST_IDLE: begin
          if (granted && req_valid) begin
            // take the bus on the edge after grant
            state_nxt.st = ST_START;
            state_nxt.own_n = 1'b0;
            state_nxt.drv = 1'b1;
            // strobe for the first clock only
            state_nxt.ts_n = 1'b0;
            state_nxt.accept = 1'b1;
            // negate request as the access begins
            state_nxt.br_n = PIN_NEGATED_N;
            state_nxt.addr = req_addr;
            state_nxt.wdata = req_wdata;
            // high for read, low for write
            state_nxt.rw = req_read;
            // write data held until the acknowledge capture
            state_nxt.data_oe = ~req_read;
            state_nxt.size = req_size;
            state_nxt.tt = req_type;
            state_nxt.dram = req_dram;
            case (req_type)
              TT_NORMAL: begin
                // code bit during, supervisor bit after
                state_nxt.access_modifier = req_mod[MOD_CODE_BIT];
                state_nxt.atm_after = req_mod[MOD_SUPER_BIT];
              end
              TT_DEBUG: begin
                state_nxt.access_modifier = req_mod[MOD_CODE_BIT];
                state_nxt.atm_after = 1'b1;
              end
              TT_DMA: begin
                state_nxt.access_modifier = ATM_DMA_DURING;
                state_nxt.atm_after = ATM_DMA_AFTER;
              end
              default: begin
                // interrupt acknowledge high, control move low
                state_nxt.access_modifier = req_mod[MOD_IACK_BIT];
                state_nxt.atm_after = ATM_CPU_AFTER;
              end
            endcase
          end else if (!state_r.own_n) begin
            // idle and unlocked: release on grant loss
            // idle and locked: keep the bus
            if (!granted && !bus_lock) begin
              state_nxt.own_n = PIN_NEGATED_N;
              state_nxt.drv = 1'b0;
            end
          end else if (granted && bus_lock) begin
            state_nxt.own_n = 1'b0;
            state_nxt.drv = 1'b1;
          end else if (!granted && !cycle_start_strobe_n_i) begin
            // type and modifier not looked at here
            state_nxt.alt_start = 1'b1;
            state_nxt.alt_read = rw_i;
            state_nxt.alt_size = size_i;
            state_nxt.alt_dram = alt_dram_hit;
            state_nxt.alt_cnt = alt_wait_states;
            if (alt_dram_hit || (alt_cs_hit && alt_master_auto_ack)) begin
              state_nxt.st = ST_ALT;
            end
          end
          // new request while grant is negated
          if (req_valid && !granted) begin
            state_nxt.br_n = 1'b0;
          end
        end
        ST_START: begin
          state_nxt.st = ST_WAIT;
          state_nxt.ts_n = PIN_NEGATED_N;
          state_nxt.access_modifier = state_r.atm_after;
        end
        ST_WAIT: begin
          if (req_valid && !granted) begin
            state_nxt.br_n = 1'b0;
          end
          if (state_r.dram) begin
            // own DRAM cycles ignore the slave acknowledge
            if (dram_done) begin
              state_nxt.done = 1'b1;
              state_nxt.st = ST_IDLE;
            end
          end else if (!error_slave_ack_n) begin
            // still seen after an early async acknowledge
            state_nxt.err = 1'b1;
            state_nxt.st = ST_IDLE;
          end else if (!sync_slave_ack_n_i) begin
            state_nxt.done = 1'b1;
            state_nxt.rdata = data_i;
            state_nxt.st = ST_IDLE;
          end else if (ata_seen) begin
            // data came from the falling-edge capture
            state_nxt.done = 1'b1;
            state_nxt.rdata = ata_data;
            state_nxt.st = ST_IDLE;
          end
          if (state_nxt.st == ST_IDLE) begin
            state_nxt.data_oe = 1'b0;
            // release after the transfer on grant loss unless locked
            if (!granted && !bus_lock) begin
              state_nxt.own_n = PIN_NEGATED_N;
              state_nxt.drv = 1'b0;
            end
          end
        end
        ST_ALT: begin
          // DRAM acknowledges at completion, others after wait states
          if (state_r.alt_dram ? alt_dram_done : (state_r.alt_cnt == '0)) begin
            state_nxt.ta_n = 1'b0;
            state_nxt.ta_oe = 1'b1;
            state_nxt.st = ST_ALT_ACK;
          end else if (!state_r.alt_dram) begin
            state_nxt.alt_cnt = state_r.alt_cnt - 1'b1;
          end
        end
        ST_ALT_ACK: begin
          state_nxt.ta_n = PIN_NEGATED_N;
          state_nxt.ta_oe = 1'b0;
          state_nxt.st = ST_IDLE;
        end
        default: begin
          state_nxt = CORE_RST;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= CORE_RST;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign req_accept = state_r.accept;
  assign xfer_done = state_r.done;
  assign xfer_error = state_r.err;
  assign xfer_rdata = state_r.rdata;
  assign addr_o = state_r.addr;
  assign addr_oe = state_r.drv;
  assign data_o = state_r.wdata;
  assign data_oe = state_r.data_oe;
  assign rw_o = state_r.rw;
  assign rw_oe = state_r.drv;
  assign size_o = state_r.size;
  assign size_oe = state_r.drv;
  assign transfer_type_field_o = state_r.tt;
  assign transfer_type_field_oe = state_r.drv;
  assign access_modifier_o = state_r.access_modifier;
  assign access_modifier_oe = state_r.drv;
  assign cycle_start_strobe_n_o = state_r.ts_n;
  assign cycle_start_strobe_oe = state_r.drv;
  assign sync_slave_ack_n_o = state_r.ta_n;
  assign sync_slave_ack_oe = state_r.ta_oe;
  assign bus_request_out_n = state_r.br_n;
  assign bus_owned_out_n = state_r.own_n;
  assign alt_cycle_start = state_r.alt_start;
  assign alt_read = state_r.alt_read;
  assign alt_size = state_r.alt_size;
  assign reset_exception = state_r.rst_exc;
  assign in_reset = state_r.in_rst;
  assign master_reset_mode = state_r.master_rst;
  assign refresh_reset = state_r.refresh_rst;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence s_strobe_pulse;
    !cycle_start_strobe_n_o ##1 cycle_start_strobe_n_o;
  endsequence

  a_strobe_one_clock: assert property (req_accept |-> s_strobe_pulse)
    else $error("start strobe not exactly one clock");

  a_dir_follows_req: assert property (req_accept |-> rw_o == $past(req_read) && rw_oe)
    else $error("direction differs from request");

  a_size_follows_req: assert property (req_accept |-> size_o == $past(req_size))
    else $error("size differs from request");

  a_type_follows_req: assert property (req_accept |->
    transfer_type_field_o == $past(req_type))
    else $error("transfer type differs from request");

  a_atm_normal_seq: assert property (req_accept && $past(req_type) == TT_NORMAL |->
    access_modifier_o == $past(req_mod[MOD_CODE_BIT])
    ##1 access_modifier_o == $past(req_mod[MOD_SUPER_BIT], 2))
    else $error("normal access modifier sequence wrong");

  a_atm_dma_seq: assert property (req_accept && $past(req_type) == TT_DMA |->
    access_modifier_o ##1 !access_modifier_o)
    else $error("DMA access modifier sequence wrong");

  a_req_negated: assert property (req_accept |-> bus_request_out_n)
    else $error("bus request still asserted at access start");

  a_take_on_grant: assert property (state_r.st == ST_IDLE && !bus_grant_in_n && req_valid
    && reset_input_pin_n |=> state_r.st == ST_START && !bus_owned_out_n)
    else $error("bus not taken on grant");

  a_owned_cause: assert property ($fell(bus_owned_out_n) |->
    $past(!bus_grant_in_n && (req_valid || bus_lock)))
    else $error("bus driven asserted without cause");

  a_idle_release: assert property (state_r.st == ST_IDLE && !bus_owned_out_n && bus_grant_in_n
    && !bus_lock && reset_input_pin_n |=> bus_owned_out_n && !addr_oe)
    else $error("bus not released after grant loss");

  a_lock_keeps_bus: assert property (state_r.st == ST_IDLE && !bus_owned_out_n && bus_grant_in_n
    && bus_lock && reset_input_pin_n |=> !bus_owned_out_n)
    else $error("locked bus released");

  a_error_priority: assert property (state_r.st == ST_WAIT && !state_r.dram
    && !error_slave_ack_n && reset_input_pin_n |=> xfer_error && !xfer_done)
    else $error("error acknowledge lost priority");

  a_dram_ignores_acks: assert property (state_r.st == ST_WAIT && state_r.dram && !dram_done
    |=> !xfer_done && !xfer_error)
    else $error("DRAM cycle ended by slave acknowledge");

  a_async_ack_data: assert property (state_r.st == ST_WAIT && !state_r.dram && ata_seen
    && error_slave_ack_n && sync_slave_ack_n_i && reset_input_pin_n
    |=> xfer_done && xfer_rdata == $past(ata_data))
    else $error("async acknowledge data not returned");

  a_reset_tristate: assert property (!reset_input_pin_n |=> !addr_oe && !cycle_start_strobe_oe
    && bus_request_out_n && bus_owned_out_n)
    else $error("reset pin did not tristate bus");

  a_master_reset: assert property (!reset_input_pin_n && !high_impedance_select_n
    |=> refresh_reset && master_reset_mode)
    else $error("master reset not entered");

  a_normal_reset: assert property (!reset_input_pin_n && high_impedance_select_n
    |=> !refresh_reset && in_reset)
    else $error("normal reset cleared refresh");

  a_alt_detect: assert property (state_r.st == ST_IDLE && bus_owned_out_n && bus_grant_in_n
    && !cycle_start_strobe_n_i && reset_input_pin_n
    |=> alt_cycle_start && alt_read == $past(rw_i))
    else $error("alternate cycle start missed");

  a_alt_dram_ack: assert property (state_r.st == ST_ALT && state_r.alt_dram && alt_dram_done
    && reset_input_pin_n |=> sync_slave_ack_oe && !sync_slave_ack_n_o
    ##1 !sync_slave_ack_oe)
    else $error("alternate DRAM acknowledge wrong");

endmodule
`default_nettype wire

// *** pkg/bcca_pkg.sv ***
// Shared encodings, field positions and reset values of the bus cycle controller
package bcca_pkg;

  // ****************************************************************
  // Field widths
  // ****************************************************************
  localparam int SIZE_W = 2;
  localparam int TT_W = 2;
  localparam int MOD_W = 2;

  // ****************************************************************
  // Transfer size encoding
  // ****************************************************************
  localparam logic [SIZE_W-1:0] SIZE_LONG = 2'h0;
  localparam logic [SIZE_W-1:0] SIZE_BYTE = 2'h1;
  localparam logic [SIZE_W-1:0] SIZE_WORD = 2'h2;
  localparam logic [SIZE_W-1:0] SIZE_LINE = 2'h3;

  // ****************************************************************
  // Transfer type encoding
  // ****************************************************************
  localparam logic [TT_W-1:0] TT_NORMAL = 2'h0;
  localparam logic [TT_W-1:0] TT_DMA = 2'h1;
  localparam logic [TT_W-1:0] TT_DEBUG = 2'h2;
  localparam logic [TT_W-1:0] TT_CPU = 2'h3;

  // ****************************************************************
  // Internal modifier fields and access modifier values
  // ****************************************************************
  // Normal and debug: bit 1 supervisor, bit 0 code fetch
  localparam int MOD_SUPER_BIT = 1;
  localparam int MOD_CODE_BIT = 0;
  // CPU space: bit 0 set for interrupt acknowledge, clear for control move
  localparam int MOD_IACK_BIT = 0;
  localparam logic ATM_DMA_DURING = 1'b1;
  localparam logic ATM_DMA_AFTER = 1'b0;
  localparam logic ATM_CPU_AFTER = 1'b0;

  // ****************************************************************
  // Reset values of active-low pins
  // ****************************************************************
  localparam logic PIN_NEGATED_N = 1'b1;

  // ****************************************************************
  // Controller states
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_WAIT,
    ST_ALT,
    ST_ALT_ACK
  } bcca_state_e;

endpackage

// *** design/bcca_ack_sync.sv ***
// Synchroniser and falling-edge data capture for the asynchronous acknowledge
`timescale 1ns/100ps
`default_nettype none
module bcca_ack_sync #(
  parameter int DW = 32
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic async_slave_ack_n,
  input wire logic arm,
  input wire logic [DW-1:0] data_i,
  output logic ack_seen,
  output logic [DW-1:0] data_held
);
  import bcca_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } bcca_sync_s;

  bcca_sync_s sync_r;
  bcca_sync_s sync_nxt;
  logic seen_r;
  logic [DW-1:0] held_r;

  // ****************************************************************
  // Two-stage synchroniser plus edge stage
  // ****************************************************************
  always_comb begin
    sync_nxt = sync_r;
    sync_nxt.s1 = ~async_slave_ack_n;
    sync_nxt.s2 = sync_r.s1;
    sync_nxt.s3 = sync_r.s2;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sync_r <= '0;
    end else begin
      sync_r <= sync_nxt;
    end
  end

  // ****************************************************************
  // Falling-edge capture
  // ****************************************************************
  // latch on falling edge
  // slave holds data past this edge
  // Only the rising edge of the synced level arms a capture, so a slave
  // that holds the acknowledge long cannot end the following cycle too
  always_ff @(negedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      seen_r <= 1'b0;
      held_r <= '0;
    end else if (!arm) begin
      seen_r <= 1'b0;
    end else if (sync_r.s2 && !sync_r.s3 && !seen_r) begin
      seen_r <= 1'b1;
      held_r <= data_i;
    end
  end

  assign ack_seen = seen_r;
  assign data_held = held_r;

endmodule
`default_nettype wire

// *** verif/bcca_slave.sv ***
// Slave model answering own cycles with a sync, async or error acknowledge
`timescale 1ns/100ps
`default_nettype none
module bcca_slave (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic strobe_n,
  input wire logic err_mode,
  input wire logic async_mode,
  input wire logic [2:0] dly,
  input wire logic [31:0] rdata,
  output logic ack_n,
  output logic err_n,
  output wire logic aack_n,
  output wire logic [31:0] data
);
  logic [2:0] cnt;
  logic [1:0] hold;
  // async ack and data stand three clocks, past the capture edge
  assign aack_n = (hold == 2'h0);
  // Inverted data outside the ack window so stale data cannot match
  assign data = (ack_n && aack_n) ? ~rdata : rdata;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= 3'h0;
      hold <= 2'h0;
      ack_n <= 1'b1;
      err_n <= 1'b1;
    end else begin
      ack_n <= 1'b1;
      err_n <= 1'b1;
      if (!strobe_n) cnt <= dly;
      else if (cnt != 3'h0) cnt <= cnt - 3'h1;
      if (hold != 2'h0) hold <= hold - 2'h1;
      if (cnt == 3'h1) begin
        if (err_mode) err_n <= 1'b0;
        else if (async_mode) hold <= 2'h3;
        else ack_n <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// *** verif/tb.sv ***
// Self-checking bench for the bus cycle controller
`timescale 1ns/100ps
`default_nettype none
module tb;
  import bcca_pkg::*;
  logic clk_sys = 0, reset_n = 0, req_valid = 0, req_read = 0, req_dram = 0, dram_done = 0;
  logic bus_lock = 0, asy = 0, alt_ts_n = 1, bus_grant_in_n = 0, alt_cs_hit = 0;
  logic alt_dram_hit = 0, alt_master_auto_ack = 0, alt_dram_done = 0, err = 0;
  logic reset_input_pin_n = 1, high_impedance_select_n = 1, sl_ack_n;
  logic [1:0] req_size = 0, req_type = 0, req_mod = 0, size_o, transfer_type_field_o, alt_size, e;
  logic [3:0] alt_wait_states = 0;
  logic [2:0] dly = 1;
  logic [31:0] req_addr = 0, req_wdata = 0, data_o, xfer_rdata, addr_o, rd = 0, r;
  logic req_accept, xfer_done, xfer_error, addr_oe, data_oe, rw_o, rw_oe, size_oe;
  logic transfer_type_field_oe, access_modifier_o, access_modifier_oe, cycle_start_strobe_n_o;
  logic cycle_start_strobe_oe, sync_slave_ack_n_o, sync_slave_ack_oe, bus_request_out_n;
  logic bus_owned_out_n, alt_cycle_start, alt_read, reset_exception, in_reset;
  logic master_reset_mode, refresh_reset;
  wire logic [31:0] data_i;
  wire logic [1:0] size_i;
  wire logic rw_i, cycle_start_strobe_n_i, sync_slave_ack_n_i, error_slave_ack_n, async_slave_ack_n;
  int bad_count = 0, comparisons = 0, k;
  // Released direction and size lines read as the inverse so nothing stale is mistaken for a drive
  // Released strobe shows the alternate master's drive
  assign cycle_start_strobe_n_i = cycle_start_strobe_oe ? cycle_start_strobe_n_o : alt_ts_n;
  assign rw_i = rw_oe ? rw_o : ~rw_o;
  assign size_i = size_oe ? size_o : ~size_o;
  assign sync_slave_ack_n_i = sync_slave_ack_oe ? sync_slave_ack_n_o : sl_ack_n;
  bcca_core bcca_core_i (.*);
  bcca_slave bcca_slave_i (.clk_sys(clk_sys), .reset_n(reset_n),
    .strobe_n(cycle_start_strobe_n_i), .err_mode(err), .async_mode(asy), .dly(dly), .rdata(rd),
    .ack_n(sl_ack_n), .err_n(error_slave_ack_n), .aack_n(async_slave_ack_n), .data(data_i));
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // Modifier value during then after the strobe
  function automatic logic [1:0] em(input logic [1:0] t, input logic [1:0] m);
    case (t)
      TT_NORMAL: em = {m[MOD_CODE_BIT], m[MOD_SUPER_BIT]};
      TT_DMA: em = {ATM_DMA_DURING, ATM_DMA_AFTER};
      TT_DEBUG: em = {m[MOD_CODE_BIT], 1'b1};
      default: em = {m[MOD_IACK_BIT], ATM_CPU_AFTER};
    endcase
  endfunction
  task chk(input logic [31:0] g, input logic [31:0] x);
    comparisons++;
    if (g !== x) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, x);
    end
  endtask
  task stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    stop_test;
  end
  initial begin
    r = 32'ha9adb0bf;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys) reset_n = 1;
    for (int i = 0; i < 12; i++) begin
      r = xs(r);
      @(negedge clk_sys);
      {req_type, req_mod, req_read, req_size} = r[6:0];
      {alt_cs_hit, alt_dram_hit, alt_master_auto_ack, alt_wait_states} = r[13:7];
      dly = {1'b0, r[9:8]} + 3'h1;
      err = (i % 5 == 4);
      req_dram = (i % 3 == 1);
      asy = r[15] & ~req_dram;
      rd = xs(r);
      req_wdata = r;
      req_addr = ~r;
      e = em(req_type, req_mod);
      req_valid = 1;
      for (k = 0; k < 20 && req_accept !== 1'b1; k++) @(posedge clk_sys) #1;
      chk(k < 20, 1);
      chk(addr_o, req_addr);
      chk(data_o, req_wdata);
      chk(data_oe, !req_read);
      chk(cycle_start_strobe_n_o, 0);
      chk(cycle_start_strobe_oe, 1);
      chk(access_modifier_o, e[1]);
      chk(transfer_type_field_o, req_type);
      chk(size_o, req_size);
      chk(rw_o, req_read);
      chk(bus_request_out_n, 1);
      @(negedge clk_sys) req_valid = 0;
      @(posedge clk_sys) #1;
      chk(access_modifier_o, e[0]);
      chk(cycle_start_strobe_n_o, 1);
      if (req_dram) begin
        repeat (6) @(negedge clk_sys);
        dram_done = 1;
        @(negedge clk_sys) dram_done = 0;
      end
      for (k = 0; k < 20 && (xfer_done | xfer_error) !== 1'b1; k++) @(posedge clk_sys) #1;
      chk(k < 20, 1);
      chk(xfer_error, err && !req_dram);
      if (req_read && !err && !req_dram) chk(xfer_rdata, rd);
      $display("cycle %0d done", i);
    end
    @(negedge clk_sys) bus_grant_in_n = 1;
    req_valid = 1;
    repeat (2) @(posedge clk_sys) #1;
    chk(bus_request_out_n, 0);
    chk(req_accept, 0);
    @(negedge clk_sys) alt_ts_n = 0;
    alt_dram_hit = 1;
    @(negedge clk_sys) alt_ts_n = 1;
    alt_dram_done = 1;
    chk({alt_cycle_start, alt_read, alt_size}, {1'b1, ~rw_o, ~size_o});
    @(negedge clk_sys) alt_dram_done = 0;
    chk({sync_slave_ack_oe, sync_slave_ack_n_o}, 2'h2);
    @(negedge clk_sys) req_valid = 0;
    chk(sync_slave_ack_oe, 0);
    // grant returns only while bus-driven is negated
    bus_grant_in_n = 0;
    bus_lock = 1;
    @(negedge clk_sys) bus_grant_in_n = 1;
    chk(bus_owned_out_n, 0);
    @(negedge clk_sys) bus_lock = 0;
    chk(bus_owned_out_n, 0);
    @(negedge clk_sys);
    chk({bus_owned_out_n, addr_oe}, 2'h2);
    $display("no grant test done");
    @(negedge clk_sys) reset_input_pin_n = 0;
    high_impedance_select_n = 0;
    @(posedge clk_sys) #1;
    chk(reset_exception, 1);
    @(posedge clk_sys) #1;
    chk(reset_exception, 0);
    chk({cycle_start_strobe_oe, addr_oe, data_oe, access_modifier_oe}, 0);
    chk({bus_request_out_n, bus_owned_out_n, in_reset}, 3'h7);
    chk({master_reset_mode, refresh_reset}, 2'h3);
    @(negedge clk_sys) high_impedance_select_n = 1;
    @(posedge clk_sys) #1;
    chk(refresh_reset, 0);
    @(negedge clk_sys) reset_input_pin_n = 1;
    $display("reset pin test done");
    stop_test;
  end
endmodule
`default_nettype wire
